// >>> cpu_bit_and_atomic_ops.sv
// Behaviour
// - A push copies the chosen register to the stack in one cycle plus memory adjustment, flags kept.
// - A pop loads the chosen register from the stack in two cycles plus adjustment, flags kept.
// - load_and_or_memory returns the old byte to the register and writes back register OR byte.
// - load_and_clear_memory returns the old byte and writes back the byte AND (0xff minus register).
// - load_and_xor_memory returns the old byte and writes back register XOR byte, in two cycles.
// - rotate_left_carry moves carry into bit 0 and bit 7 into carry, updating Z, C, N, V and H.
// - rotate_right_carry moves carry into bit 7 and bit 0 into carry, updating Z, C, N, V only.
// - io_bit_set forces one bit of an I/O register to one in a single cycle, flags kept.
// - io_bit_clear forces one bit of an I/O register to zero in a single cycle, flags kept.
// - store_bit_to_transfer_flag copies a register bit into the transfer flag, nothing else.
// - load_bit_from_transfer_flag copies the transfer flag into a register bit, flags kept.
// - sign_flag_set and sign_flag_clear drive the signed-test flag in one cycle.
// - overflow_flag_set and overflow_flag_clear drive the overflow flag in one cycle.
// - half_carry_set and half_carry_clear drive the half-carry flag in one cycle.
// - A data-memory operation that lands in internal SRAM takes one extra cycle.
// - The counts hold for internal memory only; the external window takes its own wait.
`timescale 1ns/1ps
`include "cpu_ops_params.svh"

module cpu_bit_and_atomic_ops #(
	parameter int AW = 8,
	parameter int DEPTH = 256
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import cpu_ops_pkg::*;

	initial
	begin
		if (AW != 8)
			$error("cpu_bit_and_atomic_ops: the map is laid out for 8-bit data addresses");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction : merge

	function automatic region_e region_of(input logic [7:0] a);
		if (a <= `IO_TOP)
			return RG_IO;
		else if (a <= `SRAM_TOP)
			return RG_SRAM;
		else
			return RG_EXT;
	endfunction : region_of

	function automatic logic [4:0] base_cycles(input op_e op);
		case (op)
			OP_POP, OP_LOAD_OR, OP_LOAD_CLR, OP_LOAD_XOR: return `CYC_TWO;
			default: return `CYC_ONE;
		endcase
	endfunction : base_cycles

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] rf_q [32];
	logic [7:0] ptr_q;
	logic [7:0] flags_q;
	logic [7:0] sp_q;
	cmd_s cmd_q;
	logic [4:0] rsel_q;
	logic [4:0] extw_q;
	logic [4:0] cnt_q;
	logic [4:0] last_cyc_q;
	state_e st_q;

	logic aw_full_q;
	logic w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// ----------------------------------------------------------------
	// Execution datapath
	// ----------------------------------------------------------------
	logic [7:0] ex_addr;
	logic [7:0] mem_a;
	logic [7:0] mem_b;
	logic [4:0] total;
	logic is_mem_op;
	logic commit;
	alu_out_s res;

	always_comb
	begin
		case (cmd_q.op)
			OP_PUSH: ex_addr = sp_q;
			OP_POP: ex_addr = sp_q + 8'h01;
			default: ex_addr = ptr_q;
		endcase
	end

	assign is_mem_op = cmd_q.op inside {OP_PUSH, OP_POP, OP_LOAD_OR, OP_LOAD_CLR, OP_LOAD_XOR};

	// I/O bit operations never see the SRAM penalty; the external window
	// replaces it with a software-set wait.
	always_comb
	begin
		total = base_cycles(cmd_q.op);
		if (is_mem_op && region_of(ex_addr) == RG_SRAM)
			total = total + `SRAM_EXTRA;
		else if (is_mem_op && region_of(ex_addr) == RG_EXT)
			total = total + extw_q;
	end

	assign commit = (st_q == ST_EXEC) && (cnt_q >= total);

	op_alu u_alu (
		.cmd(cmd_q),
		.reg_in(rf_q[cmd_q.rd]),
		.mem_in(mem_a),
		.flags_in(flags_q),
		.res(res)
	);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	logic have_aw;
	logic have_w;
	logic do_write;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic wr_ok;
	logic idle;

	assign idle = (st_q == ST_IDLE);
	assign have_aw = aw_full_q | (awvalid & awready);
	assign have_w = w_full_q | (wvalid & wready);
	assign do_write = have_aw & have_w & ~bvalid;
	assign wa = aw_full_q ? aw_addr_q : awaddr;
	assign wd = w_full_q ? w_data_q : wdata;
	assign ws = w_full_q ? w_strb_q : wstrb;

	// Every write is refused while an operation runs, so the operands it
	// latched cannot change under it.
	always_comb
	begin
		case ({wa[7:2], 2'b00})
			`OFS_CMD, `OFS_PTR, `OFS_FLAGS, `OFS_SP, `OFS_RSEL,
			`OFS_RDAT, `OFS_MDAT, `OFS_EXTW: wr_ok = idle;
			default: wr_ok = 1'b0;
		endcase
	end

	logic wr_cmd;
	logic mem_bus_we;
	logic [31:0] wm;

	assign wr_cmd = do_write && wr_ok && {wa[7:2], 2'b00} == `OFS_CMD;
	assign mem_bus_we = do_write && wr_ok && {wa[7:2], 2'b00} == `OFS_MDAT && ws[0];

	always_comb
	begin
		case ({wa[7:2], 2'b00})
			`OFS_CMD: wm = merge(32'(cmd_q.op) | (32'(cmd_q.rd) << `CMD_RD_LSB)
				| (32'(cmd_q.sel) << `CMD_SEL_LSB), wd, ws);
			`OFS_PTR: wm = merge(32'(ptr_q), wd, ws);
			`OFS_FLAGS: wm = merge(32'(flags_q), wd, ws);
			`OFS_SP: wm = merge(32'(sp_q), wd, ws);
			`OFS_RSEL: wm = merge(32'(rsel_q), wd, ws);
			`OFS_RDAT: wm = merge(32'(rf_q[rsel_q]), wd, ws);
			`OFS_EXTW: wm = merge(32'(extw_q), wd, ws);
			default: wm = merge(32'(mem_b), wd, ws);
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			aw_full_q <= have_aw & ~do_write;
			w_full_q <= have_w & ~do_write;
			// Both channels stay closed through the cycle in which the response is
			// raised; a second address or word taken after that waits in its holding
			// register until the first write has been answered.
			awready <= ~have_aw;
			wready <= ~have_w;
			if (awvalid && awready)
				aw_addr_q <= awaddr;
			if (wvalid && wready)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Software registers and sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 5'h00;
			last_cyc_q <= 5'h00;
			cmd_q <= '{op: OP_NOP, rd: 5'h00, sel: 3'h0};
		end
		else if (wr_cmd)
		begin
			cmd_q.op <= op_e'(wm[`CMD_OP_LSB +: 5]);
			cmd_q.rd <= wm[`CMD_RD_LSB +: 5];
			cmd_q.sel <= wm[`CMD_SEL_LSB +: 3];
			st_q <= ST_EXEC;
			cnt_q <= `CYC_ONE;
		end
		else if (commit)
		begin
			st_q <= ST_IDLE;
			last_cyc_q <= total;
		end
		else if (st_q == ST_EXEC)
			cnt_q <= cnt_q + `CYC_ONE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ptr_q <= 8'h00;
			rsel_q <= 5'h00;
			extw_q <= `EXTW_RST;
		end
		else if (do_write && wr_ok)
		begin
			if ({wa[7:2], 2'b00} == `OFS_PTR)
				ptr_q <= wm[7:0];
			if ({wa[7:2], 2'b00} == `OFS_RSEL)
				rsel_q <= wm[4:0];
			if ({wa[7:2], 2'b00} == `OFS_EXTW)
				extw_q <= wm[4:0];
		end
	end

	// The stack grows downward: a push stores then decrements, a pop
	// increments then loads.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sp_q <= `SRAM_TOP;
		else if (commit && cmd_q.op == OP_PUSH)
			sp_q <= sp_q - 8'h01;
		else if (commit && cmd_q.op == OP_POP)
			sp_q <= sp_q + 8'h01;
		else if (do_write && wr_ok && {wa[7:2], 2'b00} == `OFS_SP)
			sp_q <= wm[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_q <= `FLAGS_RST;
		else if (commit)
			flags_q <= res.flags;
		else if (do_write && wr_ok && {wa[7:2], 2'b00} == `OFS_FLAGS)
			flags_q <= wm[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 32; i++)
				rf_q[i] <= 8'h00;
		end
		else if (commit && res.wr_reg)
			rf_q[cmd_q.rd] <= res.reg_val;
		else if (do_write && wr_ok && {wa[7:2], 2'b00} == `OFS_RDAT)
			rf_q[rsel_q] <= wm[7:0];
	end

	// ----------------------------------------------------------------
	// Data space
	// ----------------------------------------------------------------
	data_space #(
		.AW(AW),
		.DEPTH(DEPTH)
	) u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.we((commit && res.wr_mem) || mem_bus_we),
		.waddr(commit ? ex_addr : ptr_q),
		.wdata(commit ? res.mem_val : wm[7:0]),
		.raddr_a(ex_addr),
		.rdata_a(mem_a),
		.raddr_b(ptr_q),
		.rdata_b(mem_b)
	);

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	logic rd_ok;

	always_comb
	begin
		rd_ok = 1'b1;
		case ({araddr[7:2], 2'b00})
			`OFS_CMD: rd_mux = 32'(cmd_q.op) | (32'(cmd_q.rd) << `CMD_RD_LSB)
				| (32'(cmd_q.sel) << `CMD_SEL_LSB);
			`OFS_PTR: rd_mux = 32'(ptr_q);
			`OFS_FLAGS: rd_mux = 32'(flags_q);
			`OFS_SP: rd_mux = 32'(sp_q);
			`OFS_STAT: rd_mux = (32'(st_q == ST_EXEC) << `STAT_BUSY)
				| (32'(last_cyc_q) << `STAT_CYC_LSB);
			`OFS_RSEL: rd_mux = 32'(rsel_q);
			`OFS_RDAT: rd_mux = 32'(rf_q[rsel_q]);
			`OFS_MDAT: rd_mux = 32'(mem_b);
			`OFS_EXTW: rd_mux = 32'(extw_q);
			default:
			begin
				rd_mux = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
		else if (!rvalid)
			arready <= 1'b1;
	end

endmodule : cpu_bit_and_atomic_ops

// >>> cpu_ops_params.svh
`ifndef CPU_OPS_PARAMS_SVH
`define CPU_OPS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_PTR 8'h04
`define OFS_FLAGS 8'h08
`define OFS_SP 8'h0c
`define OFS_STAT 8'h10
`define OFS_RSEL 8'h14
`define OFS_RDAT 8'h18
`define OFS_MDAT 8'h1c
`define OFS_EXTW 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_RD_LSB 8
`define CMD_SEL_LSB 16
`define STAT_BUSY 0
`define STAT_CYC_LSB 8
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6

// ----------------------------------------------------------------
// Reset values, map and timing
// ----------------------------------------------------------------
`define FLAGS_RST 8'h00
`define EXTW_RST 5'h01
`define IO_TOP 8'h3f
`define SRAM_TOP 8'hdf
`define CYC_ONE 5'h01
`define CYC_TWO 5'h02
`define SRAM_EXTRA 5'h01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> cpu_ops_pkg.sv
package cpu_ops_pkg;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_PUSH = 5'h01, OP_POP = 5'h02,
		OP_LOAD_OR = 5'h03, OP_LOAD_CLR = 5'h04, OP_LOAD_XOR = 5'h05,
		OP_ROT_LEFT = 5'h06, OP_ROT_RIGHT = 5'h07,
		OP_IO_SET = 5'h08, OP_IO_CLEAR = 5'h09,
		OP_T_STORE = 5'h0a, OP_T_LOAD = 5'h0b,
		OP_SIGN_SET = 5'h0c, OP_SIGN_CLR = 5'h0d,
		OP_OVF_SET = 5'h0e, OP_OVF_CLR = 5'h0f,
		OP_HALF_SET = 5'h10, OP_HALF_CLR = 5'h11
	} op_e;

	typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} state_e;

	typedef enum logic [1:0] {RG_IO = 2'b00, RG_SRAM = 2'b01, RG_EXT = 2'b11} region_e;

	typedef struct packed {
		op_e op;
		logic [4:0] rd;
		logic [2:0] sel;
	} cmd_s;

	typedef struct packed {
		logic [7:0] reg_val;
		logic [7:0] mem_val;
		logic [7:0] flags;
		logic wr_reg;
		logic wr_mem;
	} alu_out_s;

	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction : bit_mask

endpackage : cpu_ops_pkg

// >>> op_alu.sv
`timescale 1ns/1ps
`include "cpu_ops_params.svh"

module op_alu (
	input cpu_ops_pkg::cmd_s cmd,
	input wire logic [7:0] reg_in,
	input wire logic [7:0] mem_in,
	input wire logic [7:0] flags_in,
	output cpu_ops_pkg::alu_out_s res
);
	import cpu_ops_pkg::*;

	always_comb
	begin
		res = '{reg_val: reg_in, mem_val: mem_in, flags: flags_in, wr_reg: 1'b0, wr_mem: 1'b0};
		case (cmd.op)
			OP_PUSH:
			begin
				res.mem_val = reg_in;
				res.wr_mem = 1'b1;
			end
			OP_POP:
			begin
				res.reg_val = mem_in;
				res.wr_reg = 1'b1;
			end
			OP_LOAD_OR, OP_LOAD_CLR, OP_LOAD_XOR:
			begin
				res.reg_val = mem_in;
				res.wr_reg = 1'b1;
				res.wr_mem = 1'b1;
				if (cmd.op == OP_LOAD_OR)
					res.mem_val = reg_in | mem_in;
				else if (cmd.op == OP_LOAD_CLR)
					res.mem_val = (8'hff - reg_in) & mem_in;
				else
					res.mem_val = reg_in ^ mem_in;
			end
			OP_ROT_LEFT, OP_ROT_RIGHT:
			begin
				res.wr_reg = 1'b1;
				if (cmd.op == OP_ROT_LEFT)
				begin
					res.reg_val = {reg_in[6:0], flags_in[`FLAG_C]};
					res.flags[`FLAG_C] = reg_in[7];
					res.flags[`FLAG_H] = reg_in[3];
				end
				else
				begin
					res.reg_val = {flags_in[`FLAG_C], reg_in[7:1]};
					res.flags[`FLAG_C] = reg_in[0];
				end
				res.flags[`FLAG_Z] = (res.reg_val == 8'h00);
				res.flags[`FLAG_N] = res.reg_val[7];
				res.flags[`FLAG_V] = res.reg_val[7] ^ res.flags[`FLAG_C];
			end
			OP_IO_SET:
			begin
				res.mem_val = mem_in | bit_mask(cmd.sel);
				res.wr_mem = 1'b1;
			end
			OP_IO_CLEAR:
			begin
				res.mem_val = mem_in & ~bit_mask(cmd.sel);
				res.wr_mem = 1'b1;
			end
			OP_T_STORE: res.flags[`FLAG_T] = |(reg_in & bit_mask(cmd.sel));
			OP_T_LOAD:
			begin
				res.reg_val = flags_in[`FLAG_T] ? (reg_in | bit_mask(cmd.sel))
					: (reg_in & ~bit_mask(cmd.sel));
				res.wr_reg = 1'b1;
			end
			OP_SIGN_SET, OP_SIGN_CLR: res.flags[`FLAG_S] = (cmd.op == OP_SIGN_SET);
			OP_OVF_SET, OP_OVF_CLR: res.flags[`FLAG_V] = (cmd.op == OP_OVF_SET);
			OP_HALF_SET, OP_HALF_CLR: res.flags[`FLAG_H] = (cmd.op == OP_HALF_SET);
			default: res.wr_reg = 1'b0;
		endcase
	end

endmodule : op_alu

// >>> data_space.sv
`timescale 1ns/1ps
`include "cpu_ops_params.svh"

module data_space #(
	parameter int AW = 8,
	parameter int DEPTH = 256
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [7:0] rdata_b
);
	import cpu_ops_pkg::*;

	initial
	begin
		if (DEPTH > (1 << AW) || DEPTH < 1)
			$error("data_space: DEPTH does not fit the address width");
	end

	logic [7:0] mem_q [DEPTH];

	// Out-of-range addresses read zero and drop writes.
	assign rdata_a = (int'(raddr_a) < DEPTH) ? mem_q[raddr_a] : 8'h00;
	assign rdata_b = (int'(raddr_b) < DEPTH) ? mem_q[raddr_b] : 8'h00;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= 8'h00;
		end
		else if (we && int'(waddr) < DEPTH)
			mem_q[waddr] <= wdata;
	end

endmodule : data_space

// >>> cpu_ops_props.sv
`timescale 1ns/1ps
module cpu_ops_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Reset itself is the cause here, so this one stays armed while reset is low.
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !awready && !wready
		&& !arready && !bvalid && !rvalid) else $error("handshake high after reset");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("no write response");
	a_aw_closed: assert property (awvalid && awready |=> !awready)
		else $error("awready stayed high");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not reopened");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("no read response");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response not held");
	a_r_release: assert property (rvalid && rready |=> !rvalid ##1 arready)
		else $error("read channel not reopened");
	a_bresp_legal: assert property (bvalid |-> bresp[0] == 1'b0)
		else $error("illegal write response code");
	c_write_done: cover property (bvalid && bready);
	c_read_done: cover property (rvalid && rready);
	c_refused: cover property (bvalid && bresp == 2'b10);
endmodule : cpu_ops_props

bind cpu_bit_and_atomic_ops cpu_ops_props u_props (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .rresp(rresp));

// >>> host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
	input wire logic aclk,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	output logic awvalid,
	output logic [7:0] awaddr,
	output logic wvalid,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic bready,
	output logic arvalid,
	output logic [7:0] araddr,
	output logic rready
);
	initial
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;

	// Released payload is inverted so a stale value can never pass for a live one.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 1'b0;
		r = 2'bxx;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 200 && !ok; i++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				{awvalid, awaddr} <= {1'b0, ~a};
			if (wvalid && wready)
				{wvalid, wdata} <= {1'b0, ~d};
			if (bvalid && bready)
			begin
				r = bresp;
				bready <= 1'b0;
				ok = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 1'b0;
		r = 2'bxx;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 200 && !ok; i++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				{arvalid, araddr} <= {1'b0, ~a};
			if (rvalid && rready)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				ok = 1'b1;
			end
		end
	endtask : rd
endmodule : host_bus_model

// >>> tb_cpu_bit_and_atomic_ops.sv
`timescale 1ns/1ps
`include "cpu_ops_params.svh"
module tb_cpu_bit_and_atomic_ops;
	import cpu_ops_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, c;
	logic [7:0] awaddr, araddr, r, m, f, s, a, er, em, ef, es;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [4:0] op, rdx, n, ew;
	logic [2:0] sel;
	bit ok;
	int failures, checked, seed;
	host_bus_model host (.aclk(aclk), .awready(awready), .wready(wready), .bvalid(bvalid),
		.bresp(bresp), .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
		.awvalid(awvalid), .awaddr(awaddr), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb),
		.bready(bready), .arvalid(arvalid), .araddr(araddr), .rready(rready));
	cpu_bit_and_atomic_ops dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp));
	task close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task hung;
		if (!ok)
		begin
			failures++;
			close_out;
		end
	endtask : hung
	task w(input logic [7:0] ad, input logic [31:0] dd);
		host.wr(ad, dd, rs, ok);
		hung;
		chk("bresp", rs, `RESP_OKAY);
	endtask : w
	task rc(input string nm, input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk);
		host.rd(ad, d, rs, ok);
		hung;
		chk("rresp", rs, `RESP_OKAY);
		chk(nm, d & mk, ex & mk);
	endtask : rc
	task wait_idle;
		for (int k = 0; k < 64; k++)
		begin
			host.rd(`OFS_STAT, d, rs, ok);
			hung;
			if (d[`STAT_BUSY] === 1'b0)
				return;
		end
		failures++;
		close_out;
	endtask : wait_idle
	task model;
		er = r;
		em = m;
		ef = f;
		es = s;
		n = `CYC_ONE;
		case (op)
			OP_PUSH: em = r;
			OP_LOAD_OR: em = r | m;
			OP_LOAD_CLR: em = m & ~r;
			OP_LOAD_XOR: em = r ^ m;
			OP_ROT_LEFT: er = {r[6:0], f[`FLAG_C]};
			OP_ROT_RIGHT: er = {f[`FLAG_C], r[7:1]};
			OP_IO_SET: em[sel] = 1'b1;
			OP_IO_CLEAR: em[sel] = 1'b0;
			OP_T_STORE: ef[`FLAG_T] = r[sel];
			OP_T_LOAD: er[sel] = f[`FLAG_T];
			OP_SIGN_SET, OP_SIGN_CLR: ef[`FLAG_S] = !op[0];
			OP_OVF_SET, OP_OVF_CLR: ef[`FLAG_V] = !op[0];
			OP_HALF_SET, OP_HALF_CLR: ef[`FLAG_H] = !op[0];
			default: ;
		endcase
		if (op inside {OP_POP, OP_LOAD_OR, OP_LOAD_CLR, OP_LOAD_XOR})
		begin
			er = m;
			n = `CYC_TWO;
		end
		if (op == OP_PUSH)
			es = s - 8'h01;
		if (op == OP_POP)
			es = s + 8'h01;
		if (op <= OP_LOAD_XOR)
			n = n + ((a > `SRAM_TOP) ? ew : (a > `IO_TOP) ? `SRAM_EXTRA : 5'h00);
		if (op == OP_ROT_LEFT || op == OP_ROT_RIGHT)
		begin
			c = (op == OP_ROT_LEFT) ? r[7] : r[0];
			ef[`FLAG_C] = c;
			ef[`FLAG_Z] = (er == 8'h00);
			ef[`FLAG_N] = er[7];
			ef[`FLAG_V] = er[7] ^ c;
		end
		if (op == OP_ROT_LEFT)
			ef[`FLAG_H] = r[3];
	endtask : model
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial
	begin
		aresetn = 1'b0;
		seed = 32'h6032;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rc("flags reset", `OFS_FLAGS, `FLAGS_RST, 32'hff);
		rc("stack reset", `OFS_SP, `SRAM_TOP, 32'hff);
		rc("extw reset", `OFS_EXTW, `EXTW_RST, 32'h1f);
		rc("stat reset", `OFS_STAT, 32'h0, 32'h1f01);
		host.rd(8'h24, d, rs, ok);
		hung;
		chk("unmapped rresp", rs, `RESP_SLVERR);
		chk("unmapped rdata", d, 32'h0);
		host.wr(8'h24, $random(seed), rs, ok);
		hung;
		chk("unmapped bresp", rs, `RESP_SLVERR);
		ew = 5'h03;
		w(`OFS_EXTW, ew);
		// Every operation runs three times with fresh data, so all regions get visited.
		for (int i = 0; i < 51; i++)
		begin
			op = 5'(1 + i % 17);
			rdx = 5'($random(seed));
			sel = 3'($random(seed));
			r = 8'($random(seed));
			m = 8'($random(seed));
			f = 8'($random(seed));
			s = 8'($random(seed));
			a = 8'($random(seed));
			if (s == 8'hff)
				s = 8'hfe;
			if (op == OP_IO_SET || op == OP_IO_CLEAR)
				a[7:6] = 2'b00;
			if (op == OP_PUSH)
				a = s;
			if (op == OP_POP)
				a = s + 8'h01;
			w(`OFS_RSEL, rdx);
			w(`OFS_RDAT, r);
			w(`OFS_PTR, a);
			w(`OFS_MDAT, m);
			w(`OFS_SP, s);
			w(`OFS_FLAGS, f);
			w(`OFS_CMD, {13'h0, sel, 3'h0, rdx, 3'h0, op});
			wait_idle;
			model;
			rc("register", `OFS_RDAT, er, 32'hff);
			rc("memory", `OFS_MDAT, em, 32'hff);
			rc("flags", `OFS_FLAGS, ef, 32'hff);
			rc("stack", `OFS_SP, es, 32'hff);
			rc("cycles", `OFS_STAT, {19'h0, n, 8'h00}, 32'h1f01);
		end
		// A long external wait leaves room to try a second command while busy.
		w(`OFS_EXTW, 32'h14);
		w(`OFS_SP, 32'hf0);
		w(`OFS_CMD, {27'h0, OP_POP});
		host.wr(`OFS_CMD, {27'h0, OP_PUSH}, rs, ok);
		hung;
		chk("busy bresp", rs, `RESP_SLVERR);
		rc("busy", `OFS_STAT, 32'h1, 32'h1);
		wait_idle;
		rc("ext cycles", `OFS_STAT, 32'h1600, 32'h1f01);
		rc("stack after refusal", `OFS_SP, 32'hf1, 32'hff);
		close_out;
	end
endmodule : tb_cpu_bit_and_atomic_ops
